// file: cam_addr_decoder.sv
// Fetch sequencer and top level of the addressing-mode decoder
`timescale 1ns/1ps
module cam_addr_decoder (
  input wire logic clock_i, // 40 MHz clock
  input wire logic rst_i, // Async reset, active high
  input wire logic start_i, // Decode next instruction
  input wire logic pc_load_i, // Load program counter
  input wire logic [15:0] pc_value_i, // New program counter
  input wire logic [7:0] x_idx_i, // First index register
  input wire logic [7:0] y_idx_i, // Second index register
  input wire logic [7:0] mem_rdata_i, // Memory read data
  input wire logic mem_rvalid_i, // Read data valid
  input wire logic wake_i, // Interrupt, ends low power
  output cam_pkg::cam_mreq_t mem_req_o, // Read request pulse
  output logic busy_o, // Decoder not idle
  output logic done_o, // Result valid pulse
  output cam_pkg::cam_res_t result_o, // Decode result
  output logic [15:0] pc_o, // Program counter
  output logic [1:0] imask_o, // Interrupt mask level
  output logic halt_o, // Oscillator stop request
  output logic wait_o // Wait low power request
);
  import cam_pkg::*;

  // State and data registers
  cam_state_e state_q;
  cam_state_e state_d;
  cam_pre_e pre_q;
  cam_pre_e pre_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [7:0] opc_q;
  logic [7:0] opc_d;
  logic dbl_q;
  logic dbl_d;
  logic [7:0] ext0_q;
  logic [7:0] ext0_d;
  logic [7:0] ext1_q;
  logic [7:0] ext1_d;
  logic [7:0] ptr0_q;
  logic [7:0] ptr0_d;
  logic [7:0] ptr1_q;
  logic [7:0] ptr1_d;
  logic ext_idx_q;
  logic ext_idx_d;
  logic ptr_idx_q;
  logic ptr_idx_d;
  cam_mreq_t req_q;
  cam_mreq_t req_d;
  cam_res_t res_q;
  cam_res_t res_d;
  logic done_q;
  logic done_d;
  logic busy_q;
  logic [1:0] imask_q;
  logic [1:0] imask_d;
  logic halt_q;
  logic halt_d;
  logic wait_q;
  logic wait_d;

  // Decode of the captured opcode
  cam_dec_t dec;
  logic [15:0] ea;
  logic [15:0] target;

  cam_op_classify u_classify (
    .opcode_i (opc_q),
    .pre_i (pre_q),
    .dec_o (dec)
  );

  // Index register picked by prebyte
  wire [7:0] idx_sel = dec.use_y ? y_idx_i : x_idx_i;

  cam_ea_calc u_ea (
    .amode_i (dec.amode),
    .idx_i (idx_sel),
    .ext0_i (ext0_q),
    .ext1_i (ext1_q),
    .ptr0_i (ptr0_q),
    .ptr1_i (ptr1_q),
    .pc_i (pc_q),
    .ea_o (ea),
    .target_o (target)
  );

  // Prebyte recognition on the incoming byte
  wire is_pre = (mem_rdata_i == PRE_Y) || (mem_rdata_i == PRE_IND) ||
                (mem_rdata_i == PRE_IND_Y);
  wire cam_pre_e pre_code = (mem_rdata_i == PRE_Y) ? P_Y :
                            (mem_rdata_i == PRE_IND) ? P_IND : P_IND_Y;

  // Legality, byte counts and next addresses
  wire legal = dec.legal && !dbl_q;
  wire [15:0] pc_inc = pc_q + 16'h0001;
  wire [1:0] ext_next = {1'b0, ext_idx_q} + 2'h1;
  wire [1:0] ptr_next = {1'b0, ptr_idx_q} + 2'h1;
  wire [7:0] ptr_base = ext_idx_q ? ext0_q : mem_rdata_i;
  wire [7:0] ptr_second = ext0_q + 8'h01;
  wire [2:0] len_pre = {2'h0, pre_q != P_NONE};
  wire [2:0] len_ext = legal ? {1'b0, dec.ext_cnt} : 3'h0;
  wire [2:0] len_all = len_pre + 3'h1 + len_ext;

  // Inherent side effects
  wire inh_ok = legal && (dec.amode == AM_INH);
  wire sel_setm = inh_ok && (opc_q[OPC_SEL_MSB:0] == INH_SETM);
  wire sel_clrm = inh_ok && (opc_q[OPC_SEL_MSB:0] == INH_CLRM);
  wire sel_halt = inh_ok && (opc_q[OPC_SEL_MSB:0] == INH_HALT);
  wire sel_wait = inh_ok && (opc_q[OPC_SEL_MSB:0] == INH_WAIT);

  // Next-state logic of the fetch sequencer
  always_comb begin
    state_d = state_q;
    pre_d = pre_q;
    pc_d = pc_q;
    opc_d = opc_q;
    dbl_d = dbl_q;
    ext0_d = ext0_q;
    ext1_d = ext1_q;
    ptr0_d = ptr0_q;
    ptr1_d = ptr1_q;
    ext_idx_d = ext_idx_q;
    ptr_idx_d = ptr_idx_q;
    req_d = '0;
    res_d = res_q;
    done_d = 1'b0;
    imask_d = imask_q;
    halt_d = halt_q;
    wait_d = wait_q;
    case (state_q)
      S_IDLE: begin
        if (pc_load_i) begin
          pc_d = pc_value_i;
        end else if (start_i) begin
          req_d.rd = 1'b1;
          req_d.addr = pc_q;
          pre_d = P_NONE;
          dbl_d = 1'b0;
          state_d = S_OPC;
        end
      end
      S_OPC: begin
        if (mem_rvalid_i) begin
          pc_d = pc_inc;
          if (is_pre && (pre_q == P_NONE)) begin
            pre_d = pre_code;
            req_d.rd = 1'b1;
            req_d.addr = pc_inc;
          end else begin
            opc_d = mem_rdata_i;
            dbl_d = is_pre;
            state_d = S_DEC;
          end
        end
      end
      S_DEC: begin
        ext_idx_d = 1'b0;
        ptr_idx_d = 1'b0;
        if (legal && (dec.ext_cnt != 2'h0)) begin
          req_d.rd = 1'b1;
          req_d.addr = pc_q;
          state_d = S_EXT;
        end else begin
          state_d = S_DONE;
        end
      end
      S_EXT: begin
        if (mem_rvalid_i) begin
          pc_d = pc_inc;
          if (ext_idx_q) begin
            ext1_d = mem_rdata_i;
          end else begin
            ext0_d = mem_rdata_i;
          end
          if (ext_next < dec.ext_cnt) begin
            ext_idx_d = 1'b1;
            req_d.rd = 1'b1;
            req_d.addr = pc_inc;
          end else if (dec.ptr_cnt != 2'h0) begin
            req_d.rd = 1'b1;
            req_d.addr = {ZERO_PAGE, ptr_base};
            state_d = S_PTR;
          end else begin
            state_d = S_DONE;
          end
        end
      end
      S_PTR: begin
        if (mem_rvalid_i) begin
          if (ptr_idx_q) begin
            ptr1_d = mem_rdata_i;
          end else begin
            ptr0_d = mem_rdata_i;
          end
          if (ptr_next < dec.ptr_cnt) begin
            ptr_idx_d = 1'b1;
            req_d.rd = 1'b1;
            req_d.addr = {ZERO_PAGE, ptr_second};
          end else begin
            state_d = S_DONE;
          end
        end
      end
      S_DONE: begin
        res_d.ea = ea;
        res_d.target = target;
        res_d.operand = ext0_q;
        res_d.len = len_all;
        res_d.amode = dec.amode;
        res_d.group = legal ? dec.group : G_NONE;
        res_d.sel = opc_q[OPC_SEL_MSB:0];
        res_d.legal = legal;
        done_d = 1'b1;
        if (sel_setm) begin
          imask_d = IMASK_SET;
        end
        if (sel_clrm) begin
          imask_d = IMASK_CLR;
        end
        halt_d = sel_halt;
        wait_d = sel_wait;
        state_d = (sel_halt || sel_wait) ? S_SLEEP : S_IDLE;
      end
      S_SLEEP: begin
        if (wake_i) begin
          halt_d = 1'b0;
          wait_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      pre_q <= P_NONE;
      pc_q <= PC_RESET;
      opc_q <= 8'h00;
      dbl_q <= 1'b0;
      ext_idx_q <= 1'b0;
      ptr_idx_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pre_q <= pre_d;
      pc_q <= pc_d;
      opc_q <= opc_d;
      dbl_q <= dbl_d;
      ext_idx_q <= ext_idx_d;
      ptr_idx_q <= ptr_idx_d;
    end
  end

  // Fetched extension and pointer bytes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ext0_q <= 8'h00;
      ext1_q <= 8'h00;
      ptr0_q <= 8'h00;
      ptr1_q <= 8'h00;
    end else begin
      ext0_q <= ext0_d;
      ext1_q <= ext1_d;
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
    end
  end

  // Output registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= '0;
      res_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      imask_q <= IMASK_RESET;
      halt_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      req_q <= req_d;
      res_q <= res_d;
      done_q <= done_d;
      busy_q <= state_d != S_IDLE;
      imask_q <= imask_d;
      halt_q <= halt_d;
      wait_q <= wait_d;
    end
  end

  // Port drive
  assign mem_req_o = req_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign result_o = res_q;
  assign pc_o = pc_q;
  assign imask_o = imask_q;
  assign halt_o = halt_q;
  assign wait_o = wait_q;

endmodule : cam_addr_decoder

// file: cam_ea_calc.sv
// Effective address and relative target arithmetic
`timescale 1ns/1ps
module cam_ea_calc (
  input wire cam_pkg::cam_amode_e amode_i, // Addressing mode
  input wire logic [7:0] idx_i, // Selected index register
  input wire logic [7:0] ext0_i, // First byte after opcode
  input wire logic [7:0] ext1_i, // Second byte after opcode
  input wire logic [7:0] ptr0_i, // First pointer byte
  input wire logic [7:0] ptr1_i, // Second pointer byte
  input wire logic [15:0] pc_i, // Address after instruction
  output logic [15:0] ea_o, // Operand address
  output logic [15:0] target_o // Relative branch target
);
  import cam_pkg::*;

  // Operand words and zero-extended index
  wire [15:0] idx16 = {ZERO_PAGE, idx_i};
  wire [15:0] ext_w = {ext0_i, ext1_i};
  wire [15:0] ptr_w = {ptr0_i, ptr1_i};
  wire bitrel = (amode_i == AM_BITREL_D) || (amode_i == AM_BITREL_I);
  wire [7:0] ofs8 = (amode_i == AM_REL_I) ? ptr0_i :
                    (bitrel ? ext1_i : ext0_i);
  assign target_o = pc_i + {{8{ofs8[7]}}, ofs8};

  // Address forms
  always_comb begin
    ea_o = '0;
    case (amode_i)
      AM_DIR_S: ea_o = {ZERO_PAGE, ext0_i};
      AM_DIR_L: ea_o = ext_w;
      AM_IX0: ea_o = idx16;
      AM_IX_S: ea_o = idx16 + {ZERO_PAGE, ext0_i};
      AM_IX_L: ea_o = idx16 + ext_w;
      AM_IND_S: ea_o = {ZERO_PAGE, ptr0_i};
      AM_IND_L: ea_o = ptr_w;
      AM_INDIX_S: ea_o = idx16 + {ZERO_PAGE, ptr0_i};
      AM_INDIX_L: ea_o = idx16 + ptr_w;
      AM_BIT_D: ea_o = {ZERO_PAGE, ext0_i};
      AM_BITREL_D: ea_o = {ZERO_PAGE, ext0_i};
      AM_BIT_I: ea_o = {ZERO_PAGE, ptr0_i};
      AM_BITREL_I: ea_o = {ZERO_PAGE, ptr0_i};
      default: ea_o = '0;
    endcase
  end

endmodule : cam_ea_calc

// file: cam_mem_model.sv
// Behavioural program and data memory for the decoder
`timescale 1ns/1ps
module cam_mem_model (
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Async reset, active high
  input wire cam_pkg::cam_mreq_t mem_req_i, // Read request
  input wire logic [3:0] lat_i, // Answer latency, 1 or more
  output logic [7:0] rdata_o, // Read data
  output logic rvalid_o // Read valid pulse
);
  import cam_pkg::*;
  logic [7:0] mem [0:65535]; // Byte store, filled by the bench
  logic [15:0] addr_q; // Address of the pending read

  // Idle values before any read
  initial begin
    rvalid_o = 1'b0;
    rdata_o = 8'h5A;
  end

  // One answer per request, then inverted data
  always @(posedge clock_i) begin
    if (mem_req_i.rd && !rst_i) begin
      addr_q = mem_req_i.addr;
      repeat (lat_i - 4'h1) @(posedge clock_i);
      rvalid_o <= 1'b1;
      rdata_o <= mem[addr_q];
      @(posedge clock_i);
      rvalid_o <= 1'b0;
      rdata_o <= ~mem[addr_q];
    end
  end
endmodule : cam_mem_model

// file: cam_op_classify.sv
// Opcode and prebyte classifier: mode, group, byte counts, legality
`timescale 1ns/1ps
module cam_op_classify (
  input wire logic [7:0] opcode_i, // Opcode byte
  input wire cam_pkg::cam_pre_e pre_i, // Prebyte seen
  output cam_pkg::cam_dec_t dec_o // Decode result
);
  import cam_pkg::*;

  // Opcode fields and selector classes
  cam_base_e base;
  wire [4:0] sel = opcode_i[OPC_SEL_MSB:0];
  wire is_ind = (pre_i == P_IND) || (pre_i == P_IND_Y);
  wire y_pre = (pre_i == P_Y) || (pre_i == P_IND_Y);
  wire long_ok = sel <= SEL_LONG_MAX;
  wire short_ok = sel <= SEL_SHORT_MAX;
  wire bit_op = (sel >= SEL_BIT_MIN) && (sel <= SEL_MEM_MAX);
  wire btj_op = (sel >= SEL_BTJ_MIN) && (sel <= SEL_MEM_MAX);
  assign base = cam_base_e'(opcode_i[OPC_MODE_MSB:OPC_MODE_LSB]);

  // Mode table
  always_comb begin
    dec_o = '0;
    dec_o.amode = AM_INH;
    dec_o.group = MEM_GRP[sel];
    dec_o.use_y = y_pre;
    case (base)
      B_INH: begin
        dec_o.group = INH_GRP[sel];
        dec_o.legal = (sel <= INH_MAX) && !is_ind;
      end
      B_IMM: begin
        dec_o.amode = AM_IMM;
        dec_o.ext_cnt = 2'h1;
        dec_o.legal = long_ok && !is_ind;
      end
      B_DIR_S: begin
        if (bit_op) begin
          dec_o.amode = is_ind ? (btj_op ? AM_BITREL_I : AM_BIT_I)
                               : (btj_op ? AM_BITREL_D : AM_BIT_D);
          dec_o.ext_cnt = btj_op ? 2'h2 : 2'h1;
          dec_o.ptr_cnt = {1'b0, is_ind};
          dec_o.legal = (pre_i == P_NONE) || (pre_i == P_IND);
        end else begin
          dec_o.amode = is_ind ? AM_IND_S : AM_DIR_S;
          dec_o.ext_cnt = 2'h1;
          dec_o.ptr_cnt = {1'b0, is_ind};
          dec_o.legal = short_ok && (pre_i != P_IND_Y);
        end
      end
      B_DIR_L: begin
        dec_o.amode = is_ind ? AM_IND_L : AM_DIR_L;
        dec_o.ext_cnt = is_ind ? 2'h1 : 2'h2;
        dec_o.ptr_cnt = is_ind ? 2'h2 : 2'h0;
        dec_o.legal = long_ok && (pre_i != P_IND_Y);
      end
      B_IX0: begin
        dec_o.amode = AM_IX0;
        dec_o.legal = short_ok && !is_ind;
      end
      B_IX_S: begin
        dec_o.amode = is_ind ? AM_INDIX_S : AM_IX_S;
        dec_o.ext_cnt = 2'h1;
        dec_o.ptr_cnt = {1'b0, is_ind};
        dec_o.legal = short_ok;
      end
      B_IX_L: begin
        dec_o.amode = is_ind ? AM_INDIX_L : AM_IX_L;
        dec_o.ext_cnt = is_ind ? 2'h1 : 2'h2;
        dec_o.ptr_cnt = is_ind ? 2'h2 : 2'h0;
        dec_o.legal = long_ok;
      end
      B_REL: begin
        dec_o.amode = is_ind ? AM_REL_I : AM_REL_D;
        dec_o.ext_cnt = 2'h1;
        dec_o.ptr_cnt = {1'b0, is_ind};
        dec_o.group = (sel <= REL_UNC_MAX) ? G_JUMP :
                      (sel <= REL_MAX) ? G_COND : G_NONE;
        dec_o.legal = (sel <= REL_MAX) && !y_pre;
      end
      default: begin
        dec_o.legal = 1'b0;
      end
    endcase
  end

endmodule : cam_op_classify

// file: cam_pkg.sv
// Constants, types and opcode tables for the addressing-mode decoder
// Notes on behaviour
// - Inherent instructions are the opcode byte alone
// - Immediate: opcode plus operand byte, load, compare, logic and arithmetic only
// - Short direct: one address byte, page zero
// - Long direct: two address bytes, full space
// - Indexed address is unsigned index plus offset
// - Indexed without offset: no byte, address index
// - Short indexed: one offset byte, up to 1FE
// - Long indexed: two offset bytes, full space
// - Indirect: pointer address byte, operand address read
// - Short indirect: byte pointer, page zero
// - Long indirect: word pointer, one byte follows
// - Indirect indexed: index plus fetched pointer, unsigned
// - Relative adds signed byte offset to PC
// - Relative offset inline, or read via address byte
// - Load, compare, logic, arithmetic accept long forms
// - Read-modify-write, bit, jump ops: short forms only
// - Mask-set instruction raises interrupt mask to 3
// - Mask-clear instruction lowers interrupt mask to 0
// - Halt stops oscillator; wait sleeps until interrupt
// - Recognise 77 instructions in 13 groups
// - Prebytes select second index or indirect form
package cam_pkg;

  // Prebyte codes
  localparam logic [7:0] PRE_Y = 8'h90;
  localparam logic [7:0] PRE_IND = 8'h92;
  localparam logic [7:0] PRE_IND_Y = 8'h91;

  // Reset values and mask levels
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] IMASK_RESET = 2'h3;
  localparam logic [1:0] IMASK_SET = 2'h3;
  localparam logic [1:0] IMASK_CLR = 2'h0;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // Opcode field positions
  localparam int OPC_MODE_LSB = 5;
  localparam int OPC_MODE_MSB = 7;
  localparam int OPC_SEL_MSB = 4;

  // Operation selector limits
  localparam logic [4:0] SEL_LONG_MAX = 5'h09;
  localparam logic [4:0] SEL_SHORT_MAX = 5'h18;
  localparam logic [4:0] SEL_BIT_MIN = 5'h19;
  localparam logic [4:0] SEL_BTJ_MIN = 5'h1B;
  localparam logic [4:0] SEL_MEM_MAX = 5'h1C;
  localparam logic [4:0] INH_WAIT = 5'h02;
  localparam logic [4:0] INH_HALT = 5'h03;
  localparam logic [4:0] INH_SETM = 5'h06;
  localparam logic [4:0] INH_CLRM = 5'h07;
  localparam logic [4:0] INH_MAX = 5'h1B;
  localparam logic [4:0] REL_UNC_MAX = 5'h03;
  localparam logic [4:0] REL_MAX = 5'h13;

  typedef enum logic [2:0] {
    B_INH = 3'h0, B_IMM = 3'h1, B_DIR_S = 3'h2, B_DIR_L = 3'h3,
    B_IX0 = 3'h4, B_IX_S = 3'h5, B_IX_L = 3'h6, B_REL = 3'h7
  } cam_base_e;

  typedef enum logic [1:0] {
    P_NONE = 2'h0, P_Y = 2'h1, P_IND = 2'h2, P_IND_Y = 2'h3
  } cam_pre_e;

  typedef enum logic [4:0] {
    AM_INH = 5'h00, AM_IMM = 5'h01, AM_DIR_S = 5'h02, AM_DIR_L = 5'h03,
    AM_IX0 = 5'h04, AM_IX_S = 5'h05, AM_IX_L = 5'h06, AM_IND_S = 5'h07,
    AM_IND_L = 5'h08, AM_INDIX_S = 5'h09, AM_INDIX_L = 5'h0A,
    AM_REL_D = 5'h0B, AM_REL_I = 5'h0C, AM_BIT_D = 5'h0D, AM_BIT_I = 5'h0E,
    AM_BITREL_D = 5'h0F, AM_BITREL_I = 5'h10
  } cam_amode_e;

  typedef enum logic [3:0] {
    G_LOAD = 4'h0, G_STACK = 4'h1, G_INCDEC = 4'h2, G_CMP = 4'h3,
    G_LOGIC = 4'h4, G_BITOP = 4'h5, G_BITBR = 4'h6, G_ARITH = 4'h7,
    G_SHIFT = 4'h8, G_JUMP = 4'h9, G_COND = 4'hA, G_INTM = 4'hB,
    G_CCF = 4'hC, G_NONE = 4'hF
  } cam_group_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_OPC = 3'h1, S_DEC = 3'h2, S_EXT = 3'h3,
    S_PTR = 3'h4, S_DONE = 3'h5, S_SLEEP = 3'h6
  } cam_state_e;

  // Group of each memory-operand selector
  localparam cam_group_e MEM_GRP [0:31] = '{
    G_LOAD, G_CMP, G_LOGIC, G_LOGIC, G_LOGIC, G_ARITH, G_ARITH, G_ARITH,
    G_ARITH, G_CMP, G_LOAD, G_INCDEC, G_INCDEC, G_CMP, G_LOGIC, G_LOGIC,
    G_SHIFT, G_SHIFT, G_SHIFT, G_SHIFT, G_SHIFT, G_SHIFT, G_SHIFT, G_JUMP,
    G_JUMP, G_BITOP, G_BITOP, G_BITBR, G_BITBR, G_NONE, G_NONE, G_NONE};

  // Group of each inherent selector
  localparam cam_group_e INH_GRP [0:31] = '{
    G_JUMP, G_INTM, G_INTM, G_INTM, G_JUMP, G_INTM, G_CCF, G_CCF,
    G_CCF, G_CCF, G_STACK, G_LOAD, G_LOAD, G_STACK, G_STACK, G_INCDEC,
    G_INCDEC, G_CMP, G_LOGIC, G_LOGIC, G_ARITH, G_SHIFT, G_SHIFT, G_SHIFT,
    G_SHIFT, G_SHIFT, G_SHIFT, G_SHIFT, G_NONE, G_NONE, G_NONE, G_NONE};

  typedef struct packed {
    cam_amode_e amode;
    cam_group_e group;
    logic use_y;
    logic [1:0] ext_cnt;
    logic [1:0] ptr_cnt;
    logic legal;
  } cam_dec_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] operand;
    logic [2:0] len;
    cam_amode_e amode;
    cam_group_e group;
    logic [4:0] sel;
    logic legal;
  } cam_res_t;

  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } cam_mreq_t;

endpackage : cam_pkg

// file: cam_properties.sv
// Port assertions for the addressing-mode decoder
`timescale 1ns/1ps
module cam_properties (
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic start_i, // Start
  input wire logic pc_load_i, // PC load
  input wire logic wake_i, // Wake
  input wire cam_pkg::cam_mreq_t mem_req_o, // Read request
  input wire logic busy_o, // Busy
  input wire logic done_o, // Done pulse
  input wire cam_pkg::cam_res_t result_o, // Result
  input wire logic [15:0] pc_o, // PC
  input wire logic [1:0] imask_o, // Mask level
  input wire logic halt_o, // Halt request
  input wire logic wait_o // Wait request
);
  import cam_pkg::*;
  logic [15:0] start_pc_q; // PC when a start is taken
  logic ok_d; // Legal result this cycle
  logic inh_d; // Legal inherent result

  // Result qualifiers
  assign ok_d = done_o && result_o.legal;
  assign inh_d = ok_d && result_o.amode == AM_INH;

  // Remember where decoding began
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) start_pc_q <= 16'h0000;
    else if (start_i && !pc_load_i && !busy_o) start_pc_q <= pc_o;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  rd_pulse_a: assert property (mem_req_o.rd |-> busy_o ##1 !mem_req_o.rd)
    else $error("read pulse wrong");
  pc_advance_a: assert property (done_o |-> pc_o == start_pc_q + 16'(result_o.len))
    else $error("next pc wrong");
  inh_len_a: assert property (inh_d |-> result_o.len inside {3'h1, 3'h2})
    else $error("inh length wrong");
  imm_len_a: assert property (ok_d && result_o.amode == AM_IMM |-> result_o.len inside {3'h2, 3'h3})
    else $error("imm length wrong");
  page_zero_a: assert property (ok_d && result_o.amode inside {AM_DIR_S, AM_IND_S, AM_IX0} |-> result_o.ea[15:8] == 8'h00)
    else $error("short ea above FF");
  short_ix_a: assert property (ok_d && result_o.amode inside {AM_IX_S, AM_INDIX_S} |-> result_o.ea <= 16'h01FE)
    else $error("short ea above 1FE");
  rel_target_a: assert property (ok_d && result_o.amode == AM_REL_D |-> result_o.target == pc_o + {{8{result_o.operand[7]}}, result_o.operand})
    else $error("bad rel target");
  mask_set_a: assert property (inh_d && result_o.sel == INH_SETM |-> imask_o == 2'h3)
    else $error("mask not raised to 3");
  mask_clr_a: assert property (inh_d && result_o.sel == INH_CLRM |-> imask_o == 2'h0)
    else $error("mask not lowered to 0");
  halt_sleep_a: assert property (inh_d && result_o.sel == INH_HALT |-> halt_o && busy_o && !wait_o)
    else $error("halt not entered");
  sleep_hold_a: assert property ((halt_o || wait_o) && !wake_i |=> (halt_o || wait_o) && busy_o)
    else $error("sleep left early");
  wake_end_a: assert property ((halt_o || wait_o) && wake_i |-> ##[1:2] !busy_o && !halt_o && !wait_o)
    else $error("wake ignored");
endmodule : cam_properties

bind cam_addr_decoder cam_properties u_props (.clock_i(clock_i), .rst_i(rst_i),
  .start_i(start_i), .pc_load_i(pc_load_i), .wake_i(wake_i), .mem_req_o(mem_req_o),
  .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .pc_o(pc_o),
  .imask_o(imask_o), .halt_o(halt_o), .wait_o(wait_o));

// file: tb.sv
// Self-checking testbench for the addressing-mode decoder
`timescale 1ns/1ps
module tb;
  import cam_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic pc_load_i = 1'b0;
  logic [15:0] pc_value_i = 16'h0000;
  logic [7:0] x_idx_i = 8'h00;
  logic [7:0] y_idx_i = 8'h00;
  logic wake_i = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [7:0] mem_rdata_i;
  logic mem_rvalid_i;
  cam_mreq_t mem_req_o;
  cam_res_t result_o;
  logic [15:0] pc_o;
  logic [1:0] imask_o;
  logic busy_o, done_o, halt_o, wait_o;
  int fails = 0;
  int compares = 0;
  int cycles = 0;

  // 40 MHz clock and run limit
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      conclude();
    end
  end

  cam_addr_decoder u_dut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
    .pc_load_i(pc_load_i), .pc_value_i(pc_value_i), .x_idx_i(x_idx_i), .y_idx_i(y_idx_i),
    .mem_rdata_i(mem_rdata_i), .mem_rvalid_i(mem_rvalid_i), .wake_i(wake_i),
    .mem_req_o(mem_req_o), .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
    .pc_o(pc_o), .imask_o(imask_o), .halt_o(halt_o), .wait_o(wait_o));
  cam_mem_model u_mem (.clock_i(clock_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .lat_i(lat), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Load code at p, run it, wait for done
  task automatic exec(input logic [15:0] p, input logic [31:0] b, input logic [3:0] l);
    int n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    for (int i = 0; i < 4; i++) u_mem.mem[16'(p + i)] = b[31 - 8 * i -: 8];
    lat = l;
    @(negedge clock_i);
    pc_load_i = 1'b1;
    pc_value_i = p;
    @(negedge clock_i);
    pc_load_i = 1'b0;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    chk("done", 16'h0001, {15'h0, done_o});
  endtask : exec

  task automatic res(input logic [15:0] p, input logic [2:0] l, input logic [15:0] ea,
                     input cam_amode_e m);
    chk("len", {13'h0, l}, {13'h0, result_o.len});
    chk("ea", ea, result_o.ea);
    chk("amode", {11'h0, m}, {11'h0, result_o.amode});
    chk("legal", 16'h0001, {15'h0, result_o.legal});
    chk("next pc", p + l, pc_o);
  endtask : res

  task automatic s_inherent;
    exec(16'h1000, 32'h0000_0000, 4'h1);
    res(16'h1000, 3'h1, 16'h0000, AM_INH);
    exec(16'h1000, 32'h0700_0000, 4'h2);
    chk("mask clr", 16'h0000, {14'h0, imask_o});
    chk("mask grp", {12'h0, G_CCF}, {12'h0, result_o.group});
    exec(16'h1000, 32'h0600_0000, 4'h1);
    chk("mask set", 16'h0003, {14'h0, imask_o});
  endtask : s_inherent

  task automatic s_imm_direct;
    exec(16'h1100, 32'h2055_0000, 4'h1);
    res(16'h1100, 3'h2, 16'h0000, AM_IMM);
    chk("operand", 16'h0055, {8'h00, result_o.operand});
    exec(16'h1100, 32'h2A55_0000, 4'h1);
    chk("imm clr legal", 16'h0000, {15'h0, result_o.legal});
    exec(16'h1200, 32'h4180_0000, 4'h3);
    res(16'h1200, 3'h2, 16'h0080, AM_DIR_S);
    exec(16'h1200, 32'h6912_3400, 4'h3);
    res(16'h1200, 3'h3, 16'h1234, AM_DIR_L);
    exec(16'h1200, 32'h6A12_3400, 4'h1);
    chk("long clr legal", 16'h0000, {15'h0, result_o.legal});
  endtask : s_imm_direct

  task automatic s_indexed;
    x_idx_i = 8'hFF;
    y_idx_i = 8'h11;
    exec(16'h1300, 32'h8000_0000, 4'h1);
    res(16'h1300, 3'h1, 16'h00FF, AM_IX0);
    exec(16'h1300, 32'h9080_0000, 4'h1);
    res(16'h1300, 3'h2, 16'h0011, AM_IX0);
    exec(16'h1300, 32'hA0FF_0000, 4'h2);
    res(16'h1300, 3'h2, 16'h01FE, AM_IX_S);
    exec(16'h1300, 32'hC0F0_1000, 4'h1);
    res(16'h1300, 3'h3, 16'hF10F, AM_IX_L);
  endtask : s_indexed

  task automatic s_indirect;
    u_mem.mem[16'h0030] = 8'h77;
    u_mem.mem[16'h0040] = 8'hAB;
    u_mem.mem[16'h0041] = 8'hCD;
    u_mem.mem[16'h0050] = 8'hF0;
    u_mem.mem[16'h00FF] = 8'h12;
    u_mem.mem[16'h0000] = 8'h34;
    exec(16'h1400, 32'h9240_3000, 4'h2);
    res(16'h1400, 3'h3, 16'h0077, AM_IND_S);
    exec(16'h1400, 32'h9260_4000, 4'h1);
    res(16'h1400, 3'h3, 16'hABCD, AM_IND_L);
    exec(16'h1400, 32'h92A0_5000, 4'h1);
    res(16'h1400, 3'h3, 16'h01EF, AM_INDIX_S);
    exec(16'h1400, 32'h91C0_FF00, 4'h3);
    res(16'h1400, 3'h3, 16'h1245, AM_INDIX_L);
    exec(16'h1400, 32'h9140_3000, 4'h1);
    chk("y ind dir legal", 16'h0000, {15'h0, result_o.legal});
    chk("y ind dir pc", 16'h1402, pc_o);
    exec(16'h1400, 32'h925B_3004, 4'h1);
    res(16'h1400, 3'h4, 16'h0077, AM_BITREL_I);
    chk("bitrel tgt", 16'h1408, result_o.target);
  endtask : s_indirect

  task automatic s_relative;
    exec(16'h2000, 32'hE580_0000, 4'h1);
    res(16'h2000, 3'h2, 16'h0000, AM_REL_D);
    chk("back target", 16'h1F82, result_o.target);
    chk("cond grp", {12'h0, G_COND}, {12'h0, result_o.group});
    exec(16'h2000, 32'hE07F_0000, 4'h2);
    chk("fwd target", 16'h2081, result_o.target);
    u_mem.mem[16'h0060] = 8'hFE;
    exec(16'h2000, 32'h92E1_6000, 4'h1);
    res(16'h2000, 3'h3, 16'h0000, AM_REL_I);
    chk("ind target", 16'h2001, result_o.target);
  endtask : s_relative

  // Halt then wait, each held until wake
  task automatic s_sleep;
    for (int k = 0; k < 2; k++) begin
      exec(16'h2100, {8'(3 - k), 24'h0}, 4'h1);
      chk("sleep kind", {14'h0, k[0], !k[0]}, {14'h0, wait_o, halt_o});
      repeat (4) @(negedge clock_i);
      chk("sleep busy", 16'h0001, {15'h0, busy_o});
      @(negedge clock_i);
      wake_i = 1'b1;
      repeat (2) @(negedge clock_i);
      chk("sleep end", 16'h0000, {13'h0, busy_o, halt_o, wait_o});
      wake_i = 1'b0;
    end
  endtask : s_sleep

  // Legal selector count for the inherent, short direct, long direct and relative base modes
  task automatic s_census;
    logic [2:0] base [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
    int want [4] = '{28, 29, 10, 20};
    int n;
    wake_i = 1'b1;
    for (int b = 0; b < 4; b++) begin
      n = 0;
      for (int s = 0; s < 32; s++) begin
        exec(16'h3000, {base[b], 5'(s), 24'h0}, 4'h1);
        if (result_o.legal === 1'b1) n++;
      end
      chk("legal count", 16'(want[b]), 16'(n));
    end
    wake_i = 1'b0;
  endtask : s_census

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    s_inherent();
    s_imm_direct();
    s_indexed();
    s_indirect();
    s_relative();
    s_sleep();
    s_census();
    conclude();
  end
endmodule : tb
